// ### common/wit_params.svh
// constants of the watchdog / interval timer: offsets, fields, resets, timing
// assumes a 16-bit register address space and a 100 MHz ref_clk
//
// Overview of operation
// RQ1: software sets mode select and timer enable to run as watchdog.
// RQ2: software rewrites the counter, usually with zero, before it overflows.
// RQ3: watchdog overflow asserts the chip-wide internal reset for 518 states.
// RQ4: with reset output enabled, drive external reset low 132 states, else none.
// RQ5: watchdog reset shares the pin reset vector; the flag tells them apart.
// RQ6: pin reset together with watchdog reset is treated as a pin reset.
// RQ7: interval mode: mode select 0, enable 1, interrupt at each overflow.
// RQ8: overflow sets the overflow flag and fires reset or interrupt together.
// RQ9: watchdog reset flag sets only in watchdog mode with enable set.
// RQ10: watchdog overflow sets both flags; internal reset clears only overflow.
// RQ11: reset service software must clear the watchdog reset flag itself.
// RQ12: in interval mode the interrupt stands while the overflow flag is set.
// RQ13: counter write coinciding with a tick stores the data, skips increment.
// RQ14: software halts the counter before changing the clock select field.
// RQ15: clock select 0..7 picks system clock over 2,32,64,128,256,512,2048,4096.
// RQ16: with enable clear the counter is held at zero.
// RQ17: word writes carry password 5A for counter, A5 for control.
// RQ18: overflow flag clears only after it is read as 1 then written 0.
`ifndef WIT_PARAMS_SVH
`define WIT_PARAMS_SVH

`define WIT_ADDR_TIMER_WR   16'hFFA8
`define WIT_ADDR_RSTC_WR    16'hFFAA
`define WIT_ADDR_CTRL_RD    16'hFFA8
`define WIT_ADDR_CNT_RD     16'hFFA9
`define WIT_ADDR_RSTC_RD    16'hFFAB

`define WIT_PW_COUNTER      8'h5A
`define WIT_PW_CONTROL      8'hA5
`define WIT_RSTC_CLEAR_LO   8'h00

`define WIT_BIT_OVF         7
`define WIT_BIT_MODE        6
`define WIT_BIT_TME         5
`define WIT_BIT_WATCHDOG_RESET_FLAG        7
`define WIT_BIT_RESET_OUTPUT_ENABLE_BIT       6

`define WIT_CTRL_ONES       8'h18
`define WIT_RSTC_ONES       8'h3F
`define WIT_CNT_RST         8'h00
`define WIT_CKS_RST         3'h0

`define WIT_CLK_PERIOD_NS   10
`define WIT_STATE_NS        10
`define WIT_INT_RESET_STATES 518
`define WIT_EXT_RESET_STATES 132
`define WIT_INT_RESET_CYCLES \
	((`WIT_INT_RESET_STATES * `WIT_STATE_NS + `WIT_CLK_PERIOD_NS - 1) / `WIT_CLK_PERIOD_NS)
`define WIT_EXT_RESET_CYCLES \
	((`WIT_EXT_RESET_STATES * `WIT_STATE_NS + `WIT_CLK_PERIOD_NS - 1) / `WIT_CLK_PERIOD_NS)

// listed from select code 0 upward: index 0 is the first element
`define WIT_DIV_SHIFTS '{4'h1, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hB, 4'hC}

`endif

// ### common/wit_pkg.sv
// types shared by the watchdog / interval timer modules
// assumes the constants header supplies all numeric values
package wit_pkg;

	typedef enum logic {WIT_MODE_INTERVAL, WIT_MODE_WATCHDOG} wit_mode_e;

	typedef enum logic [1:0] {WIT_PULSE_IDLE, WIT_PULSE_ACTIVE} wit_pulse_e;

	typedef logic [7:0] wit_byte_t;

endpackage : wit_pkg

// ### verilog/wit_prescaler.sv
// prescaler producing one-cycle count ticks from ref_clk
// assumes run drops whenever the counter is halted or in internal reset
`timescale 1ns/100ps
`include "wit_params.svh"
module wit_prescaler #(
	parameter int PRE_W = 12
) (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// control
	input  wire logic             run,
	input  wire logic [2:0]       clock_select,
	// tick out
	output logic                  tick
);
	localparam logic [3:0] DIV_SHIFT [8] = `WIT_DIV_SHIFTS;

	logic [PRE_W-1:0] pre_reg;
	logic [PRE_W-1:0] pre_next;
	wire  [3:0]       shift_sel;
	wire  [PRE_W-1:0] div_mask;

	// shift 12 wraps to zero, so the mask becomes all ones for the largest divide
	assign shift_sel = DIV_SHIFT[clock_select];                    // [RQ15]
	assign div_mask  = (PRE_W'(1) << shift_sel) - PRE_W'(1);
	assign pre_next  = run ? pre_reg + PRE_W'(1) : '0;
	assign tick      = run && ((pre_reg & div_mask) == div_mask);  // [RQ15]

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			pre_reg <= '0;
		else
			pre_reg <= pre_next;
	end

endmodule : wit_prescaler

// ### verilog/wit_pulse_timer.sv
// fixed-length pulse stretcher: active for LENGTH cycles after start
// assumes start is a one-cycle pulse on ref_clk; a start while active restarts
`timescale 1ns/100ps
module wit_pulse_timer #(
	parameter int CNT_W  = 10,
	parameter int LENGTH = 518
) (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic rst,
	// trigger and output
	input  wire logic start,
	output logic      active
);
	wit_pkg::wit_pulse_e state_reg;
	wit_pkg::wit_pulse_e state_next;
	logic [CNT_W-1:0]    cnt_reg;
	logic [CNT_W-1:0]    cnt_next;

	always_comb
	begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		case (state_reg)
			wit_pkg::WIT_PULSE_IDLE:
				if (start)
				begin
					state_next = wit_pkg::WIT_PULSE_ACTIVE;
					cnt_next   = CNT_W'(LENGTH - 1);
				end
			wit_pkg::WIT_PULSE_ACTIVE:
				if (start)
					cnt_next = CNT_W'(LENGTH - 1);
				else if (cnt_reg == '0)
					state_next = wit_pkg::WIT_PULSE_IDLE;
				else
					cnt_next = cnt_reg - CNT_W'(1);
			default:
				state_next = wit_pkg::WIT_PULSE_IDLE;
		endcase
	end

	assign active = (state_reg == wit_pkg::WIT_PULSE_ACTIVE);

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= wit_pkg::WIT_PULSE_IDLE;
			cnt_reg   <= '0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
		end
	end

endmodule : wit_pulse_timer

// ### verilog/wit_top.sv
// watchdog / interval timer: password-protected registers, counter, reset pulses
// assumes rst is the synchronised pin reset and the bus master is on ref_clk
`timescale 1ns/100ps
`include "wit_params.svh"
module wit_top #(
	parameter int INT_CNT_W = 10,
	parameter int EXT_CNT_W = 8
) (
	// clock and pin reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// register port
	input  wire logic [15:0] reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// reset and interrupt outputs
	output logic             chip_reset_out,
	output logic             reset_output_pin_n,
	output logic             interval_interrupt
);
	localparam int INT_CYCLES = `WIT_INT_RESET_CYCLES;
	localparam int EXT_CYCLES = `WIT_EXT_RESET_CYCLES;

	// timer control register fields
	logic                overflow_flag;
	logic                overflow_flag_next;
	wit_pkg::wit_mode_e  mode_select_bit;
	wit_pkg::wit_mode_e  mode_select_next;
	logic                timer_enable_bit;
	logic                timer_enable_next;
	logic [2:0]          clock_select_field;
	logic [2:0]          clock_select_next;
	// counter and reset control fields
	wit_pkg::wit_byte_t  timer_counter_reg;
	wit_pkg::wit_byte_t  timer_counter_next;
	logic                watchdog_reset_flag;
	logic                watchdog_reset_next;
	logic                reset_output_enable_bit;
	logic                reset_output_enable_next;
	// read-before-clear arming
	logic                ovf_armed_reg;
	logic                ovf_armed_next;
	logic                watchdog_reset_flag_armed_reg;
	logic                watchdog_reset_flag_armed_next;
	// read port
	wit_pkg::wit_byte_t  rdata_reg;
	wit_pkg::wit_byte_t  rdata_next;

	wire                 count_tick;
	wire                 int_active;
	wire                 ext_active;

	// write decode
	wire [7:0] wr_hi        = reg_wdata[15:8];
	wire [7:0] wr_lo        = reg_wdata[7:0];
	wire       wr_timer     = reg_wr && (reg_addr == `WIT_ADDR_TIMER_WR);
	wire       wr_counter   = wr_timer && (wr_hi == `WIT_PW_COUNTER);       // [RQ17]
	wire       wr_control   = wr_timer && (wr_hi == `WIT_PW_CONTROL);       // [RQ17]
	wire       wr_rstc      = reg_wr && (reg_addr == `WIT_ADDR_RSTC_WR);
	wire       wr_rstc_clr  = wr_rstc && (wr_hi == `WIT_PW_CONTROL)
	                          && (wr_lo == `WIT_RSTC_CLEAR_LO);
	wire       wr_rstc_oe   = wr_rstc && (wr_hi == `WIT_PW_COUNTER);

	// read decode
	wire       rd_ctrl      = reg_rd && (reg_addr == `WIT_ADDR_CTRL_RD);
	wire       rd_cnt       = reg_rd && (reg_addr == `WIT_ADDR_CNT_RD);
	wire       rd_rstc      = reg_rd && (reg_addr == `WIT_ADDR_RSTC_RD);

	// counter events
	wire       is_watchdog  = (mode_select_bit == wit_pkg::WIT_MODE_WATCHDOG);
	wire       counting     = timer_enable_bit && !chip_reset_out;
	// a tick during a counter write is dropped: the write wins
	wire       tick_taken   = count_tick && counting && !wr_counter;       // [RQ13]
	wire       overflow     = tick_taken && (timer_counter_reg == 8'hFF);
	wire       wd_overflow  = overflow && is_watchdog && timer_enable_bit; // [RQ9]
	wire       ovf_clear    = wr_control && ovf_armed_reg && !wr_lo[`WIT_BIT_OVF];
	wire       watchdog_reset_flag_clear   = wr_rstc_clr && watchdog_reset_flag_armed_reg;

	// read images; reserved bits read as one
	wire [7:0] ctrl_image   = {overflow_flag, is_watchdog, timer_enable_bit, 2'b00,
	                           clock_select_field} | `WIT_CTRL_ONES;
	wire [7:0] rstc_image   = {watchdog_reset_flag, reset_output_enable_bit, 6'h00}
	                          | `WIT_RSTC_ONES;

	wit_prescaler #(
		.PRE_W        (12)
	) u_prescaler (
		.ref_clk      (ref_clk),
		.rst          (rst),
		.run          (counting),
		.clock_select (clock_select_field),
		.tick         (count_tick)
	);

	// internal chip reset, started by a watchdog overflow
	wit_pulse_timer #(
		.CNT_W   (INT_CNT_W),
		.LENGTH  (INT_CYCLES)
	) u_int_reset (
		.ref_clk (ref_clk),
		.rst     (rst),
		.start   (wd_overflow),                                            // [RQ3]
		.active  (int_active)
	);

	// external reset pulse, only when the output is enabled
	wit_pulse_timer #(
		.CNT_W   (EXT_CNT_W),
		.LENGTH  (EXT_CYCLES)
	) u_ext_reset (
		.ref_clk (ref_clk),
		.rst     (rst),
		.start   (wd_overflow && reset_output_enable_bit),                 // [RQ4]
		.active  (ext_active)
	);

	// the same reset line as the pin path; software reads the flag to tell them apart
	assign chip_reset_out     = int_active;                                // [RQ5]
	assign reset_output_pin_n = !ext_active;                               // [RQ4]
	assign interval_interrupt = overflow_flag && !is_watchdog;             // [RQ12] [RQ7]
	assign reg_rdata          = rdata_reg;

	// counter: held at zero when halted or in internal reset
	assign timer_counter_next = (!counting) ? `WIT_CNT_RST :               // [RQ16]
	                            wr_counter  ? wr_lo :                      // [RQ13]
	                            tick_taken  ? timer_counter_reg + 8'h01 :
	                                          timer_counter_reg;

	// set wins over a clear in the same cycle
	assign overflow_flag_next = chip_reset_out ? 1'b0 :                    // [RQ10]
	                            overflow       ? 1'b1 :                    // [RQ8]
	                            ovf_clear      ? 1'b0 :                    // [RQ18]
	                                             overflow_flag;
	assign ovf_armed_next     = (chip_reset_out || ovf_clear || !overflow_flag) ? 1'b0 :
	                            (rd_ctrl && overflow_flag) ? 1'b1 : ovf_armed_reg;

	// control bits return to reset values during the internal reset
	assign mode_select_next   = chip_reset_out ? wit_pkg::WIT_MODE_INTERVAL :
	                            wr_control ? wit_pkg::wit_mode_e'(wr_lo[`WIT_BIT_MODE]) :
	                                         mode_select_bit;
	assign timer_enable_next  = chip_reset_out ? 1'b0 :
	                            wr_control ? wr_lo[`WIT_BIT_TME] : timer_enable_bit;
	// a select change while counting takes effect at once; software halts first
	assign clock_select_next  = chip_reset_out ? `WIT_CKS_RST :
	                            wr_control ? wr_lo[2:0] : clock_select_field;

	// reset control bits survive the internal reset; the pin reset or a software write clears them
	assign watchdog_reset_next = wd_overflow ? 1'b1 :                      // [RQ10]
	                             watchdog_reset_flag_clear  ? 1'b0 :                      // [RQ11]
	                                           watchdog_reset_flag;
	assign watchdog_reset_flag_armed_next     = (watchdog_reset_flag_clear || !watchdog_reset_flag) ? 1'b0 :
	                             (rd_rstc && watchdog_reset_flag) ? 1'b1 : watchdog_reset_flag_armed_reg;
	assign reset_output_enable_next = wr_rstc_oe ? wr_lo[`WIT_BIT_RESET_OUTPUT_ENABLE_BIT] :
	                                               reset_output_enable_bit;

	// unmapped reads return zero
	assign rdata_next = rd_ctrl ? ctrl_image :
	                    rd_cnt  ? timer_counter_reg :
	                    rd_rstc ? rstc_image : 8'h00;

	// pin reset clears everything, so a coincident watchdog overflow is lost
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)                                                           // [RQ6]
		begin
			overflow_flag           <= 1'b0;
			mode_select_bit         <= wit_pkg::WIT_MODE_INTERVAL;
			timer_enable_bit        <= 1'b0;
			clock_select_field      <= `WIT_CKS_RST;
			timer_counter_reg       <= `WIT_CNT_RST;
			ovf_armed_reg           <= 1'b0;
		end
		else
		begin
			overflow_flag           <= overflow_flag_next;
			mode_select_bit         <= mode_select_next;
			timer_enable_bit        <= timer_enable_next;
			clock_select_field      <= clock_select_next;
			timer_counter_reg       <= timer_counter_next;
			ovf_armed_reg           <= ovf_armed_next;
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)                                                           // [RQ6]
		begin
			watchdog_reset_flag     <= 1'b0;
			reset_output_enable_bit <= 1'b0;
			watchdog_reset_flag_armed_reg          <= 1'b0;
			rdata_reg               <= 8'h00;
		end
		else
		begin
			watchdog_reset_flag     <= watchdog_reset_next;
			reset_output_enable_bit <= reset_output_enable_next;
			watchdog_reset_flag_armed_reg          <= watchdog_reset_flag_armed_next;
			rdata_reg               <= rdata_next;
		end
	end

	// helper counters measuring pulse lengths
	logic [15:0] int_len_reg;
	logic [15:0] ext_len_reg;

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			int_len_reg <= 16'h0000;
			ext_len_reg <= 16'h0000;
		end
		else
		begin
			int_len_reg <= chip_reset_out ? int_len_reg + 16'h0001 : 16'h0000;
			ext_len_reg <= !reset_output_pin_n ? ext_len_reg + 16'h0001 : 16'h0000;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	sequence wd_fire_s;
		wd_overflow;
	endsequence

	sequence reset_hold_s;
		(watchdog_reset_flag && chip_reset_out)[*8];
	endsequence

	sequence ovf_read_s;
		rd_ctrl && overflow_flag && !chip_reset_out;
	endsequence

	ovf_set_a: assert property (overflow |=> overflow_flag)               // [RQ8]
		else $error("overflow did not set the overflow flag");

	wd_reset_start_a: assert property (wd_fire_s |=> chip_reset_out)      // [RQ8]
		else $error("watchdog overflow did not start the internal reset");

	int_reset_len_a: assert property ($fell(chip_reset_out)
		|-> int_len_reg == 16'(INT_CYCLES))                               // [RQ3]
		else $error("internal reset length wrong");

	ext_reset_len_a: assert property ($rose(reset_output_pin_n)
		|-> ext_len_reg == 16'(EXT_CYCLES))                               // [RQ4]
		else $error("external reset length wrong");

	ext_reset_off_a: assert property (wd_overflow && !reset_output_enable_bit
		&& reset_output_pin_n |=> reset_output_pin_n)                     // [RQ4]
		else $error("external reset driven while disabled");

	watchdog_reset_flag_hold_a: assert property (wd_fire_s |=> reset_hold_s)              // [RQ10]
		else $error("watchdog flag not held through internal reset");

	ovf_reset_clear_a: assert property ($rose(chip_reset_out) |=> !overflow_flag) // [RQ10]
		else $error("internal reset left the overflow flag set");

	watchdog_reset_flag_interval_a: assert property (overflow && !is_watchdog && !watchdog_reset_flag_clear
		|=> watchdog_reset_flag == $past(watchdog_reset_flag))            // [RQ9]
		else $error("interval overflow changed the watchdog flag");

	irq_level_a: assert property (overflow_flag && !is_watchdog
		|-> interval_interrupt)                                            // [RQ12]
		else $error("interval interrupt missing while flag set");

	write_wins_a: assert property (wr_counter && counting
		|=> timer_counter_reg == $past(reg_wdata[7:0]))                    // [RQ13]
		else $error("counter write lost against a tick");

	halt_zero_a: assert property (!timer_enable_bit |=> timer_counter_reg == 8'h00) // [RQ16]
		else $error("halted counter not at zero");

	ovf_noclear_a: assert property (overflow_flag && !ovf_armed_reg && !chip_reset_out
		|=> overflow_flag)                                                 // [RQ18]
		else $error("overflow flag cleared without a prior read");

	ovf_clear_a: assert property (ovf_read_s ##[1:2] (wr_control && !wr_lo[`WIT_BIT_OVF]
		&& !overflow && !chip_reset_out) |=> !overflow_flag)               // [RQ18]
		else $error("read then write zero did not clear the overflow flag");

endmodule : wit_top

// ### tb/wit_reset_sink.sv
// model of the external devices held in reset by the timer's reset output
// assumes the line idles high and is sampled on ref_clk like the devices' own logic
`timescale 1ns/100ps
module wit_reset_sink (
	// clock
	input  wire logic        ref_clk,
	// reset line from the timer, active low
	input  wire logic        reset_output_pin_n,
	// what the devices saw
	output logic      [7:0]  pulse_count,
	output logic      [15:0] low_len
);
	logic [15:0] run_len;

	initial
	begin
		pulse_count = 8'h00;
		low_len     = 16'h0000;
		run_len     = 16'h0000;
	end

	// devices stay held only while the line is low; an unknown level does not count as held
	always @(posedge ref_clk)
	begin
		if (reset_output_pin_n === 1'h0)
		begin
			run_len <= run_len + 16'h0001;
			if (run_len == 16'h0000)
				pulse_count <= pulse_count + 8'h01;
		end
		else if (run_len != 16'h0000)
		begin
			low_len <= run_len;
			run_len <= 16'h0000;
		end
	end
endmodule : wit_reset_sink

// ### tb/test_watchdog_interval_timer.sv
// self-checking bench for the watchdog / interval timer
// assumes default widths on wit_top and a 100 MHz ref_clk made here
`timescale 1ns/100ps
`include "wit_params.svh"
module test_watchdog_interval_timer;
	`define WIT_CHK(got, exp) \
		begin \
			tests_run++; \
			if ((got) !== (exp)) \
			begin \
				err_total++; \
				$display("Error at %0t: got %0h expected %0h", $time, got, exp); \
			end \
		end

	logic        ref_clk;
	logic        rst;
	logic [15:0] reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_rdata;
	logic        chip_reset_out;
	logic        reset_output_pin_n;
	logic        interval_interrupt;
	logic [7:0]  sink_pulses;
	logic [15:0] sink_low;
	logic        rd_seen;
	logic [7:0]  last_rd;
	logic [8:0]  exp_q[$];
	int          err_total = 0;
	int          tests_run = 0;
	int          m;
	int          len;
	int          shifts[8] = '{1, 5, 6, 7, 8, 9, 11, 12};

	wit_top dut (
		.ref_clk            (ref_clk),
		.rst                (rst),
		.reg_addr           (reg_addr),
		.reg_wdata          (reg_wdata),
		.reg_wr             (reg_wr),
		.reg_rd             (reg_rd),
		.reg_rdata          (reg_rdata),
		.chip_reset_out     (chip_reset_out),
		.reset_output_pin_n (reset_output_pin_n),
		.interval_interrupt (interval_interrupt)
	);

	wit_reset_sink sink (
		.ref_clk            (ref_clk),
		.reset_output_pin_n (reset_output_pin_n),
		.pulse_count        (sink_pulses),
		.low_len            (sink_low)
	);

	initial
	begin
		ref_clk = 1'h0;
		forever
			#5 ref_clk = ~ref_clk;
	end

	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude

	// a read answers in the next cycle only, so note which edges took a read
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			rd_seen <= 1'h0;
		else
			rd_seen <= reg_rd;
	end

	// mid-cycle look keeps clear of the edge where the data drops back to zero
	always @(negedge ref_clk)
	begin
		logic [8:0] e;
		if (rd_seen === 1'h1)
		begin
			last_rd = reg_rdata;
			if (exp_q.size() == 0)
				`WIT_CHK(1'h1, 1'h0)
			else
			begin
				e = exp_q.pop_front();
				if (!e[8])
					`WIT_CHK(reg_rdata, e[7:0])
			end
		end
	end

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'h1;
		@(posedge ref_clk);
		reg_wr    <= 1'h0;
	endtask : wr

	// bit 8 of the note marks a read whose value is only kept, not compared
	task automatic rd(input logic [15:0] a, input logic [8:0] e);
		@(posedge ref_clk);
		exp_q.push_back(e);
		reg_addr <= a;
		reg_rd   <= 1'h1;
		@(posedge ref_clk);
		reg_rd   <= 1'h0;
	endtask : rd

	task automatic wait_high(input int which, input int bound);
		int i;
		i = 0;
		while ((which == 0 ? chip_reset_out : interval_interrupt) !== 1'h1)
		begin
			@(negedge ref_clk);
			i++;
			if (i > bound)
			begin
				err_total++;
				$display("Error at %0t: wait ran out, got %0h expected %0h", $time, 0, 1);
				conclude();
			end
		end
	endtask : wait_high

	initial
	begin
		rst       = 1'h1;
		reg_addr  = 16'h0000;
		reg_wdata = 16'h0000;
		reg_wr    = 1'h0;
		reg_rd    = 1'h0;
		void'($urandom(32'hB064));
		repeat (12) @(posedge ref_clk);
		rst <= 1'h0;
		// reset values, unmapped place, wrong password
		rd(`WIT_ADDR_CTRL_RD, 9'h018);
		rd(`WIT_ADDR_CNT_RD, 9'h000);
		rd(`WIT_ADDR_RSTC_RD, 9'h03F);
		rd(16'hFFAC, 9'h000);
		wr(`WIT_ADDR_TIMER_WR, 16'h1260);
		rd(`WIT_ADDR_CTRL_RD, 9'h018);
		// every clock select: count difference over a whole number of periods
		for (int s = 0; s < 8; s++)
		begin
			m = $urandom_range(4, 2);
			wr(`WIT_ADDR_TIMER_WR, {`WIT_PW_CONTROL, 5'h04, 3'(s)});
			rd(`WIT_ADDR_CNT_RD, 9'h100);
			repeat ((m << shifts[s]) - 2) @(posedge ref_clk);
			rd(`WIT_ADDR_CNT_RD, {1'h0, last_rd + 8'(m)});
			wr(`WIT_ADDR_TIMER_WR, {`WIT_PW_CONTROL, 8'h00});
			rd(`WIT_ADDR_CNT_RD, 9'h000);
		end
		// interval mode: flag, interrupt level, clear only when armed
		wr(`WIT_ADDR_TIMER_WR, {`WIT_PW_CONTROL, 8'h20});
		wr(`WIT_ADDR_TIMER_WR, {`WIT_PW_COUNTER, 8'hFE});
		wait_high(1, 50);
		wr(`WIT_ADDR_TIMER_WR, {`WIT_PW_CONTROL, 8'h20});
		@(negedge ref_clk);
		`WIT_CHK(interval_interrupt, 1'h1)
		rd(`WIT_ADDR_CTRL_RD, 9'h0B8);
		wr(`WIT_ADDR_TIMER_WR, {`WIT_PW_CONTROL, 8'h20});
		@(negedge ref_clk);
		`WIT_CHK(interval_interrupt, 1'h0)
		rd(`WIT_ADDR_RSTC_RD, 9'h03F);
		wr(`WIT_ADDR_TIMER_WR, {`WIT_PW_CONTROL, 8'h00});
		// watchdog overflow with the reset output enabled
		wr(`WIT_ADDR_RSTC_WR, {`WIT_PW_COUNTER, 8'h40});
		rd(`WIT_ADDR_RSTC_RD, 9'h07F);
		wr(`WIT_ADDR_TIMER_WR, {`WIT_PW_CONTROL, 8'h60});
		wr(`WIT_ADDR_TIMER_WR, {`WIT_PW_COUNTER, 8'hF0});
		wait_high(0, 100);
		`WIT_CHK(reset_output_pin_n, 1'h0)
		`WIT_CHK(interval_interrupt, 1'h0)
		len = 0;
		while (chip_reset_out === 1'h1 && len < 2000)
		begin
			@(negedge ref_clk);
			len++;
		end
		`WIT_CHK(len, `WIT_INT_RESET_CYCLES)
		`WIT_CHK(sink_low, 16'(`WIT_EXT_RESET_CYCLES))
		`WIT_CHK(sink_pulses, 8'h01)
		rd(`WIT_ADDR_RSTC_RD, 9'h0FF);
		rd(`WIT_ADDR_CTRL_RD, 9'h018);
		wr(`WIT_ADDR_TIMER_WR, {`WIT_PW_CONTROL, 8'h00});
		// the read above armed the clear, so this write takes effect
		wr(`WIT_ADDR_RSTC_WR, {`WIT_PW_CONTROL, `WIT_RSTC_CLEAR_LO});
		rd(`WIT_ADDR_RSTC_RD, 9'h07F);
		wr(`WIT_ADDR_RSTC_WR, {`WIT_PW_CONTROL, `WIT_RSTC_CLEAR_LO});
		rd(`WIT_ADDR_RSTC_RD, 9'h07F);
		// output disabled, kicks in time, then a pin reset during the internal reset
		wr(`WIT_ADDR_RSTC_WR, {`WIT_PW_COUNTER, 8'h00});
		wr(`WIT_ADDR_TIMER_WR, {`WIT_PW_CONTROL, 8'h60});
		repeat (3)
		begin
			repeat (300) @(posedge ref_clk);
			wr(`WIT_ADDR_TIMER_WR, {`WIT_PW_COUNTER, 8'h00});
			@(negedge ref_clk);
			`WIT_CHK(chip_reset_out, 1'h0)
		end
		wait_high(0, 600);
		`WIT_CHK(reset_output_pin_n, 1'h1)
		repeat (10) @(posedge ref_clk);
		rst <= 1'h1;
		repeat (12) @(posedge ref_clk);
		rst <= 1'h0;
		@(negedge ref_clk);
		`WIT_CHK(chip_reset_out, 1'h0)
		rd(`WIT_ADDR_RSTC_RD, 9'h03F);
		repeat (3) @(posedge ref_clk);
		`WIT_CHK(sink_pulses, 8'h01)
		`WIT_CHK(exp_q.size(), 0)
		conclude();
	end
endmodule : test_watchdog_interval_timer
